// *** design/ioac_top.sv ***
// Input conditioning, input actions and output source selection of a motor starter, with an APB register file.
//
// Chosen here: the address map and the APB interface to the registers.
`include "ioac_regs.svh"
`default_nettype none
module ioac_top #(parameter int STEP_CYC = `IOAC_STEP_CYC, parameter int FLASH_CYC = `IOAC_FLASH_CYC) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] INPUT_RAW,
  input wire logic SENSOR_OVERLOAD,
  input wire logic OUTPUT_OVERLOAD,
  input wire logic HOST_OUTPUT_BIT_TWO,
  input wire logic EXTERNAL_SOURCE,
  input wire logic MOTOR_OFF_CMD,
  input wire logic MOTOR_CMD_ACTIVE,
  input wire ioac_pkg::ioac_starter_t STARTER,
  output ioac_pkg::ioac_cmd_t ACTION_CMD,
  output logic INPUT_CONTROL,
  output logic INPUT_WARNING,
  output logic DIGITAL_OUT,
  output logic OUTPUT_ACTIVE,
  output logic BRAKE_ACTIVE,
  output logic IRQ
);
  import ioac_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] action_cfg;
  logic [31:0] out_cfg;
  logic [`IOAC_EV_WIDTH-1:0] event_flags;
  logic [`IOAC_EV_WIDTH-1:0] event_mask;
  logic [`IOAC_EV_WIDTH-1:0] event_set;
  logic step_tick;
  logic [24:0] step_cnt;
  logic [27:0] flash_cnt;
  logic flash_phase;
  logic [3:0] filtered;
  logic [3:0] stretched;
  logic [3:0] cond;
  logic [3:0] cond_q;
  logic [3:0] act_level;
  logic [3:0] retained;
  logic end_cw_latch;
  logic end_ccw_latch;
  logic sensor_trip;
  logic out_trip;
  logic qstop_any;
  logic trip_reset_any;
  logic ack_write;
  logic ctrl_source;
  logic out_raw;
  logic out_gated;
  logic [4:0] delay_steps;
  logic [4:0] ext_steps;
  ioac_cmd_t cmd;

  wire wr_en = PSEL && PENABLE && PWRITE;
  wire rd_en = PSEL && PENABLE && !PWRITE;

  // Registers answer with no wait states.
  assign PREADY = 1'b1;

  function automatic ioac_action_t action_of(input logic [31:0] cfg, input int idx);
    action_of = ioac_action_t'(cfg[idx*4 +: 4]);
  endfunction

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `IOAC_CTRL_OFS) || (a == `IOAC_ACTION_OFS) || (a == `IOAC_OUTCFG_OFS) ||
                 (a == `IOAC_STATUS_OFS) || (a == `IOAC_EVENT_OFS) || (a == `IOAC_MASK_OFS) ||
                 (a == `IOAC_ACK_OFS);
  endfunction

  assign PSLVERR = PSEL && PENABLE && !known_addr(PADDR);

  // The delay field counts in 10 ms steps starting at one step; out-of-range codes are clamped.
  assign delay_steps = (ctrl[3:0] < 4'(`IOAC_DLY_MIN)) ? 5'(`IOAC_DLY_MIN) :
                       (ctrl[3:0] > 4'(`IOAC_DLY_MAX)) ? 5'(`IOAC_DLY_MAX) : 5'(ctrl[3:0]);
  assign ext_steps = (ctrl[8:4] > 5'(`IOAC_EXT_MAX)) ? 5'(`IOAC_EXT_MAX) : ctrl[8:4];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl <= `IOAC_CTRL_RST;
      action_cfg <= `IOAC_ACTION_RST;
      out_cfg <= `IOAC_OUTCFG_RST;
      event_mask <= '0;
    end else if (wr_en) begin
      if (PADDR == `IOAC_CTRL_OFS) begin
        ctrl <= {12'h0, PWDATA[19:12], 3'h0, PWDATA[8:0]};
      end else if (PADDR == `IOAC_ACTION_OFS) begin
        action_cfg <= PWDATA;
      end else if (PADDR == `IOAC_OUTCFG_OFS) begin
        out_cfg <= {25'h0, PWDATA[6:0]};
      end else if (PADDR == `IOAC_MASK_OFS) begin
        event_mask <= PWDATA[`IOAC_EV_WIDTH-1:0];
      end
    end
  end

  assign ack_write = wr_en && (PADDR == `IOAC_ACK_OFS) && PWDATA[0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == `IOAC_CTRL_OFS) begin
        PRDATA <= ctrl;
      end else if (PADDR == `IOAC_ACTION_OFS) begin
        PRDATA <= action_cfg;
      end else if (PADDR == `IOAC_OUTCFG_OFS) begin
        PRDATA <= out_cfg;
      end else if (PADDR == `IOAC_STATUS_OFS) begin
        PRDATA <= {16'h0, 4'h0, cond, 1'b0, end_ccw_latch, end_cw_latch, sensor_trip,
                   out_trip, BRAKE_ACTIVE, INPUT_WARNING, INPUT_CONTROL};
      end else if (PADDR == `IOAC_EVENT_OFS) begin
        PRDATA <= {26'h0, event_flags};
      end else if (PADDR == `IOAC_MASK_OFS) begin
        PRDATA <= {26'h0, event_mask};
      end else begin
        PRDATA <= '0;
      end
    end
  end

  // One 10 ms step enable shared by all filters.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      step_cnt <= '0;
      step_tick <= 1'b0;
    end else begin
      step_tick <= (step_cnt == 25'(STEP_CYC - 1));
      step_cnt <= (step_cnt == 25'(STEP_CYC - 1)) ? '0 : step_cnt + 25'h1;
    end
  end

  // Half-period counter, so the on and off phases are equally long.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else if (flash_cnt == 28'(FLASH_CYC - 1)) begin
      flash_cnt <= '0;
      flash_phase <= !flash_phase;
    end else begin
      flash_cnt <= flash_cnt + 28'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_in
      logic [4:0] dly_cnt;
      logic [4:0] ext_cnt;
      logic polar;
      assign polar = INPUT_RAW[i] ^ ctrl[12+i];

      // The shared step enable is not aligned to the change, so one extra step is counted to never accept early.
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          dly_cnt <= '0;
          filtered[i] <= 1'b0;
        end else if (polar == filtered[i]) begin
          dly_cnt <= '0;
        end else if (step_tick) begin
          if (dly_cnt >= delay_steps) begin
            filtered[i] <= polar;
            dly_cnt <= '0;
          end else begin
            dly_cnt <= dly_cnt + 5'h1;
          end
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          ext_cnt <= '0;
          stretched[i] <= 1'b0;
        end else if (filtered[i]) begin
          stretched[i] <= 1'b1;
          ext_cnt <= '0;
        end else if (stretched[i]) begin
          if (ext_steps == 5'h0) begin
            stretched[i] <= 1'b0;
          end else if (step_tick) begin
            ext_cnt <= ext_cnt + 5'h1;
            if (ext_cnt >= ext_steps) begin
              stretched[i] <= 1'b0;
            end
          end
        end
      end

      // Retentive inputs latch on the active edge; quick stop releases with the motor commands.
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          retained[i] <= 1'b0;
        end else if (sensor_trip) begin
          retained[i] <= 1'b0;
        end else if (cond[i] && !cond_q[i]) begin
          retained[i] <= 1'b1;
        end else if (MOTOR_OFF_CMD || (action_of(action_cfg, i) == IOAC_ACT_QSTOP && !MOTOR_CMD_ACTIVE)) begin
          retained[i] <= 1'b0;
        end
      end

      assign act_level[i] = ctrl[16+i] ? retained[i] : cond[i];
    end
  endgenerate

  assign cond = sensor_trip ? 4'h0 : stretched;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond;
    end
  end

  always_comb begin
    cmd = '0;
    for (int k = 0; k < 4; k++) begin
      if (act_level[k]) begin
        case (action_of(action_cfg, k))
          IOAC_ACT_TRIP: cmd.trip = 1'b1;
          IOAC_ACT_TRIP_RESTART: cmd.trip_restart = 1'b1;
          IOAC_ACT_END_CW: cmd.end_cw = 1'b1;
          IOAC_ACT_END_CCW: cmd.end_ccw = 1'b1;
          IOAC_ACT_WARN: cmd.warning = 1'b1;
          IOAC_ACT_MANUAL: cmd.manual = 1'b1;
          IOAC_ACT_EMERGENCY: cmd.emergency = 1'b1;
          IOAC_ACT_MOTOR_CW: cmd.motor_cw = 1'b1;
          IOAC_ACT_MOTOR_CCW: cmd.motor_ccw = 1'b1;
          IOAC_ACT_QSTOP: cmd.quick_stop = 1'b1;
          IOAC_ACT_TRIP_RESET: cmd.trip_reset = !cond_q[k];
          IOAC_ACT_COLD_RUN: cmd.cold_run = 1'b1;
          default: cmd.trip = cmd.trip;
        endcase
      end
    end
    // Quick stop wins over the motor commands.
    if (cmd.quick_stop) begin
      cmd.motor_cw = 1'b0;
      cmd.motor_ccw = 1'b0;
    end
  end

  assign qstop_any = cmd.quick_stop;
  assign trip_reset_any = cmd.trip_reset || ack_write;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ACTION_CMD <= '0;
      end_cw_latch <= 1'b0;
      end_ccw_latch <= 1'b0;
    end else begin
      ACTION_CMD <= cmd;
      ACTION_CMD.end_cw <= end_cw_latch || cmd.end_cw;
      ACTION_CMD.end_ccw <= end_ccw_latch || cmd.end_ccw;
      if (cmd.end_cw) begin
        end_cw_latch <= 1'b1;
      end else if (MOTOR_OFF_CMD) begin
        end_cw_latch <= 1'b0;
      end
      if (cmd.end_ccw) begin
        end_ccw_latch <= 1'b1;
      end else if (MOTOR_OFF_CMD) begin
        end_ccw_latch <= 1'b0;
      end
    end
  end

  // The overload level keeps the trip set until it is gone and a trip reset is seen; only an acknowledge write resets the sensor trip.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sensor_trip <= 1'b0;
      out_trip <= 1'b0;
    end else begin
      if (SENSOR_OVERLOAD) begin
        sensor_trip <= 1'b1;
      end else if (ack_write) begin
        sensor_trip <= 1'b0;
      end
      if (OUTPUT_OVERLOAD) begin
        out_trip <= 1'b1;
      end else if (trip_reset_any) begin
        out_trip <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      INPUT_CONTROL <= 1'b0;
      INPUT_WARNING <= 1'b0;
      BRAKE_ACTIVE <= 1'b0;
    end else begin
      INPUT_CONTROL <= cmd.manual || cmd.motor_cw || cmd.motor_ccw || cmd.quick_stop;
      INPUT_WARNING <= cmd.warning;
      BRAKE_ACTIVE <= STARTER.brake_output && !qstop_any;
    end
  end

  always_comb begin
    case (ioac_source_t'(out_cfg[4:0]))
      IOAC_SRC_EXTERNAL: ctrl_source = EXTERNAL_SOURCE;
      IOAC_SRC_HOST_BIT: ctrl_source = HOST_OUTPUT_BIT_TWO;
      IOAC_SRC_IN1: ctrl_source = cond[0];
      IOAC_SRC_IN2: ctrl_source = cond[1];
      IOAC_SRC_IN3: ctrl_source = cond[2];
      IOAC_SRC_IN4: ctrl_source = cond[3];
      IOAC_SRC_RUN_UP: ctrl_source = STARTER.run_up;
      IOAC_SRC_OPERATION: ctrl_source = STARTER.operation;
      IOAC_SRC_COAST: ctrl_source = STARTER.coasting;
      IOAC_SRC_ON_TIME: ctrl_source = STARTER.on_time;
      IOAC_SRC_ON_CMD: ctrl_source = STARTER.on_cmd;
      IOAC_SRC_BRAKE: ctrl_source = STARTER.brake_output;
      IOAC_SRC_AUX_POWER: ctrl_source = STARTER.auxiliary_power_on;
      IOAC_SRC_PREWARN: ctrl_source = STARTER.prewarning;
      IOAC_SRC_WARN: ctrl_source = STARTER.warning;
      IOAC_SRC_FAULT: ctrl_source = STARTER.fault;
      IOAC_SRC_BUS_ERR: ctrl_source = STARTER.bus_error;
      IOAC_SRC_DEV_ERR: ctrl_source = STARTER.device_error;
      IOAC_SRC_READY: ctrl_source = STARTER.ready;
      default: ctrl_source = 1'b0;
    endcase
  end

  assign out_raw = ctrl_source && (!out_cfg[6] || flash_phase);
  // An overloaded output is switched off whatever its polarity.
  assign out_gated = out_trip ? 1'b0 : (out_raw ^ out_cfg[5]);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DIGITAL_OUT <= 1'b0;
      OUTPUT_ACTIVE <= 1'b0;
    end else begin
      DIGITAL_OUT <= out_gated;
      OUTPUT_ACTIVE <= out_gated;
    end
  end

  assign event_set[`IOAC_EV_TRIP] = cmd.trip || cmd.trip_restart;
  assign event_set[`IOAC_EV_END_CW] = cmd.end_cw;
  assign event_set[`IOAC_EV_END_CCW] = cmd.end_ccw;
  assign event_set[`IOAC_EV_SENSOR] = SENSOR_OVERLOAD;
  assign event_set[`IOAC_EV_OUT_OVL] = OUTPUT_OVERLOAD;
  assign event_set[`IOAC_EV_QSTOP] = cmd.quick_stop;

  // A read clears the flags, but an event in the same cycle stays set.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      event_flags <= '0;
    end else if (rd_en && PADDR == `IOAC_EVENT_OFS) begin
      event_flags <= event_set;
    end else begin
      event_flags <= event_flags | event_set;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(event_flags & event_mask);
    end
  end
endmodule
`default_nettype wire

// *** shared/ioac_pkg.sv ***
// Types of the input/output action block.
`default_nettype none
package ioac_pkg;
  typedef enum logic [3:0] {
    IOAC_ACT_NONE, IOAC_ACT_TRIP, IOAC_ACT_TRIP_RESTART, IOAC_ACT_END_CW, IOAC_ACT_END_CCW,
    IOAC_ACT_WARN, IOAC_ACT_MANUAL, IOAC_ACT_EMERGENCY, IOAC_ACT_MOTOR_CW, IOAC_ACT_MOTOR_CCW,
    IOAC_ACT_QSTOP, IOAC_ACT_TRIP_RESET, IOAC_ACT_COLD_RUN
  } ioac_action_t;

  typedef enum logic [4:0] {
    IOAC_SRC_EXTERNAL, IOAC_SRC_HOST_BIT, IOAC_SRC_IN1, IOAC_SRC_IN2, IOAC_SRC_IN3, IOAC_SRC_IN4,
    IOAC_SRC_RUN_UP, IOAC_SRC_OPERATION, IOAC_SRC_COAST, IOAC_SRC_ON_TIME, IOAC_SRC_ON_CMD,
    IOAC_SRC_BRAKE, IOAC_SRC_AUX_POWER, IOAC_SRC_PREWARN, IOAC_SRC_WARN, IOAC_SRC_FAULT,
    IOAC_SRC_BUS_ERR, IOAC_SRC_DEV_ERR, IOAC_SRC_READY
  } ioac_source_t;

  // Starter state and message lines that the output may follow.
  typedef struct packed {
    logic run_up;
    logic operation;
    logic coasting;
    logic on_time;
    logic on_cmd;
    logic brake_output;
    logic auxiliary_power_on;
    logic prewarning;
    logic warning;
    logic fault;
    logic bus_error;
    logic device_error;
    logic ready;
  } ioac_starter_t;

  // Commands that the input actions hand to the starter.
  typedef struct packed {
    logic trip;
    logic trip_restart;
    logic end_cw;
    logic end_ccw;
    logic warning;
    logic manual;
    logic emergency;
    logic motor_cw;
    logic motor_ccw;
    logic quick_stop;
    logic trip_reset;
    logic cold_run;
  } ioac_cmd_t;
endpackage
`default_nettype wire

// *** shared/ioac_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the input/output action block.
`ifndef IOAC_REGS_SVH
`define IOAC_REGS_SVH

`define IOAC_CLK_HZ 250000000
`define IOAC_STEP_MS 10
`define IOAC_STEP_CYC ((`IOAC_CLK_HZ / 1000) * `IOAC_STEP_MS)
`define IOAC_FLASH_MS 500
`define IOAC_FLASH_CYC ((`IOAC_CLK_HZ / 1000) * `IOAC_FLASH_MS)
`define IOAC_EXT_MAX 20
`define IOAC_DLY_MIN 1
`define IOAC_DLY_MAX 8

`define IOAC_CTRL_OFS 12'h000
`define IOAC_ACTION_OFS 12'h004
`define IOAC_OUTCFG_OFS 12'h008
`define IOAC_STATUS_OFS 12'h00c
`define IOAC_EVENT_OFS 12'h010
`define IOAC_MASK_OFS 12'h014
`define IOAC_ACK_OFS 12'h018

`define IOAC_CTRL_RST 32'h0000_0001
`define IOAC_ACTION_RST 32'h0000_0000
`define IOAC_OUTCFG_RST 32'h0000_0001

// Event bit positions.
`define IOAC_EV_TRIP 0
`define IOAC_EV_END_CW 1
`define IOAC_EV_END_CCW 2
`define IOAC_EV_SENSOR 3
`define IOAC_EV_OUT_OVL 4
`define IOAC_EV_QSTOP 5
`define IOAC_EV_WIDTH 6

`endif

// *** testbench/ioac_field.sv ***
// Field side model: switches on the inputs, a sensor supply and a load on the digital output.
`default_nettype none
module ioac_field (
  input wire logic clk,
  input wire logic [3:0] switch_on,
  input wire logic sensor_short,
  input wire logic load_short,
  input wire logic digital_out,
  output logic [3:0] input_raw,
  output logic sensor_overload,
  output logic output_overload
);
  timeunit 1ns;
  timeprecision 1ps;
  assign input_raw = switch_on;
  // A shorted load only overloads the output while the output actually drives it.
  always_ff @(posedge clk) begin
    output_overload <= load_short & digital_out;
  end
  always_ff @(posedge clk) begin
    sensor_overload <= sensor_short;
  end
endmodule
`default_nettype wire

// *** testbench/ioac_top_properties.sv ***
// Concurrent checks on the ports of the input/output action block.
`default_nettype none
module ioac_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic OUTPUT_OVERLOAD,
  input wire logic SENSOR_OVERLOAD,
  input wire logic MOTOR_OFF_CMD,
  input wire ioac_pkg::ioac_starter_t STARTER,
  input wire ioac_pkg::ioac_cmd_t ACTION_CMD,
  input wire logic DIGITAL_OUT,
  input wire logic OUTPUT_ACTIVE,
  input wire logic BRAKE_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  import ioac_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_out_active_mirror: assert property (OUTPUT_ACTIVE == DIGITAL_OUT) else $error("output active differs");
  a_brake_off_follow: assert property (!$past(STARTER.brake_output) |-> !BRAKE_ACTIVE) else $error("brake active");
  a_qstop_motor: assert property (ACTION_CMD.quick_stop |-> !ACTION_CMD.motor_cw && !ACTION_CMD.motor_ccw)
    else $error("quick stop lost priority");
  a_qstop_brake: assert property (ACTION_CMD.quick_stop [*2] |-> !BRAKE_ACTIVE) else $error("brake during stop");
  a_ready_always: assert property (PREADY) else $error("ready low");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR > 12'h018 |-> PSLVERR) else $error("no slave error");
  a_mapped_ok: assert property (PSEL && PENABLE && PADDR <= 12'h018 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("spurious slave error");
  a_ovl_out_low: assert property ($past(OUTPUT_OVERLOAD, 2) |-> !DIGITAL_OUT)
    else $error("output driven in overload");
  a_reset_once: assert property (ACTION_CMD.trip_reset |=> !ACTION_CMD.trip_reset) else $error("trip reset repeated");
  a_end_latch: assert property (ACTION_CMD.end_cw && !$past(MOTOR_OFF_CMD) |=> ACTION_CMD.end_cw)
    else $error("end trip dropped");
  a_sensor_block: assert property (SENSOR_OVERLOAD [*2] |=> !ACTION_CMD.motor_cw && !ACTION_CMD.motor_ccw)
    else $error("inputs acted on in overload");
endmodule
bind ioac_top ioac_props u_props (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .OUTPUT_OVERLOAD(OUTPUT_OVERLOAD), .SENSOR_OVERLOAD(SENSOR_OVERLOAD),
  .MOTOR_OFF_CMD(MOTOR_OFF_CMD), .STARTER(STARTER), .ACTION_CMD(ACTION_CMD), .DIGITAL_OUT(DIGITAL_OUT),
  .OUTPUT_ACTIVE(OUTPUT_ACTIVE), .BRAKE_ACTIVE(BRAKE_ACTIVE));
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the input/output action block over APB and its field pins.
`include "ioac_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ioac_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, host = 1'b0, ext = 1'b0, motor_off = 1'b0, motor_cmd = 1'b0;
  logic sensor_short = 1'b0, load_short = 1'b0, sensor_ovl, out_ovl;
  logic [3:0] switch_on = 4'h0, raw;
  ioac_starter_t starter = '0;
  ioac_cmd_t action_cmd;
  logic in_ctrl, in_warn, dout, out_act, brake, irq;
  int fails = 0, comparisons = 0, cycles = 0;
  // Short step and flash counts keep the filters and the flasher inside the run's cycle budget.
  ioac_top #(.STEP_CYC(10), .FLASH_CYC(6))
    uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INPUT_RAW(raw),
    .SENSOR_OVERLOAD(sensor_ovl), .OUTPUT_OVERLOAD(out_ovl), .HOST_OUTPUT_BIT_TWO(host), .EXTERNAL_SOURCE(ext),
    .MOTOR_OFF_CMD(motor_off), .MOTOR_CMD_ACTIVE(motor_cmd), .STARTER(starter), .ACTION_CMD(action_cmd),
    .INPUT_CONTROL(in_ctrl), .INPUT_WARNING(in_warn), .DIGITAL_OUT(dout), .OUTPUT_ACTIVE(out_act),
    .BRAKE_ACTIVE(brake), .IRQ(irq));
  ioac_field field (.clk(clk), .switch_on(switch_on), .sensor_short(sensor_short), .load_short(load_short),
    .digital_out(dout), .input_raw(raw), .sensor_overload(sensor_ovl), .output_overload(out_ovl));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // The ceiling is far above the fewer than one thousand cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_reset_values();
    apb(1'b0, `IOAC_CTRL_OFS, 32'h0);
    check(rd, `IOAC_CTRL_RST);
    check(rd[8:4], 32'h0);
    check(rd[3:0], 32'h1);
    apb(1'b0, `IOAC_ACTION_OFS, 32'h0);
    check(rd, `IOAC_ACTION_RST);
    apb(1'b0, `IOAC_OUTCFG_OFS, 32'h0);
    check(rd, `IOAC_OUTCFG_RST);
    apb(1'b0, `IOAC_MASK_OFS, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_host_and_invert();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      host <= i[0];
      wait_cyc(3);
      check(dout, logic'(i[0] ^ i[1]));
      check(out_act, logic'(i[0] ^ i[1]));
      if (i == 1) apb(1'b1, `IOAC_OUTCFG_OFS, 32'h21);
    end
    apb(1'b1, `IOAC_OUTCFG_OFS, 32'h00);
    @(posedge clk);
    ext <= 1'b1;
    wait_cyc(3);
    check(dout, 1'b1);
    ext <= 1'b0;
    wait_cyc(3);
    check(dout, 1'b0);
  endtask
  task automatic t_starter_sources();
    for (int s = 6; s <= 18; s++) begin
      apb(1'b1, `IOAC_OUTCFG_OFS, 32'(s));
      starter <= ioac_starter_t'(13'h1 << (18 - s));
      wait_cyc(3);
      check(dout, 1'b1);
      starter <= ioac_starter_t'(~(13'h1 << (18 - s)));
      wait_cyc(3);
      check(dout, 1'b0);
      check(brake, logic'(s != 11));
    end
    starter <= '0;
  endtask
  task automatic t_flash();
    int n = 0;
    apb(1'b1, `IOAC_OUTCFG_OFS, 32'h41);
    host <= 1'b1;
    wait_cyc(3);
    repeat (24) begin
      @(posedge clk);
      n += int'(dout);
    end
    check(n, 32'd12);
    host <= 1'b0;
  endtask
  task automatic t_input_filter();
    apb(1'b1, `IOAC_CTRL_OFS, 32'h32);
    apb(1'b1, `IOAC_OUTCFG_OFS, 32'h2);
    switch_on <= 4'h1;
    wait_cyc(20);
    check(dout, 1'b0);
    wait_cyc(13);
    check(dout, 1'b1);
    check(action_cmd, '0);
    switch_on <= 4'h0;
    wait_cyc(50);
    check(dout, 1'b1);
    wait_cyc(25);
    check(dout, 1'b0);
    switch_on <= 4'h1;
    wait_cyc(15);
    switch_on <= 4'h0;
    wait_cyc(40);
    check(dout, 1'b0);
  endtask
  task automatic t_input_actions();
    int n = 0;
    apb(1'b1, `IOAC_CTRL_OFS, 32'h1);
    apb(1'b1, `IOAC_ACTION_OFS, 32'h53a8);
    starter <= ioac_starter_t'(13'h080);
    switch_on <= 4'h1;
    wait_cyc(25);
    check(action_cmd.motor_cw, 1'b1);
    check(in_ctrl, 1'b1);
    switch_on <= 4'h3;
    wait_cyc(25);
    check(action_cmd.motor_cw, 1'b0);
    check(action_cmd.quick_stop, 1'b1);
    check(brake, 1'b0);
    switch_on <= 4'hc;
    wait_cyc(25);
    check(action_cmd.end_cw, 1'b1);
    check(in_warn, 1'b1);
    check(brake, 1'b1);
    switch_on <= 4'h0;
    wait_cyc(25);
    check(action_cmd.end_cw, 1'b1);
    check(in_warn, 1'b0);
    motor_off <= 1'b1;
    wait_cyc(2);
    motor_off <= 1'b0;
    wait_cyc(3);
    check(action_cmd.end_cw, 1'b0);
    apb(1'b1, `IOAC_CTRL_OFS, 32'h1_0001);
    switch_on <= 4'h1;
    wait_cyc(25);
    switch_on <= 4'h0;
    wait_cyc(25);
    check(action_cmd.motor_cw, 1'b1);
    motor_off <= 1'b1;
    wait_cyc(2);
    motor_off <= 1'b0;
    wait_cyc(3);
    check(action_cmd.motor_cw, 1'b0);
    apb(1'b1, `IOAC_CTRL_OFS, 32'h1);
    apb(1'b1, `IOAC_ACTION_OFS, 32'h53ab);
    switch_on <= 4'h1;
    repeat (25) begin
      @(posedge clk);
      n += int'(action_cmd.trip_reset);
    end
    check(n, 32'd1);
    switch_on <= 4'h0;
    wait_cyc(25);
    apb(1'b1, `IOAC_ACTION_OFS, 32'h53a8);
    starter <= '0;
  endtask
  task automatic t_output_overload();
    apb(1'b1, `IOAC_OUTCFG_OFS, 32'h1);
    apb(1'b1, `IOAC_MASK_OFS, 32'h10);
    host <= 1'b1;
    wait_cyc(3);
    check(dout, 1'b1);
    load_short <= 1'b1;
    wait_cyc(5);
    check(dout, 1'b0);
    load_short <= 1'b0;
    wait_cyc(5);
    check(dout, 1'b0);
    check(irq, 1'b1);
    apb(1'b0, `IOAC_STATUS_OFS, 32'h0);
    check(rd[3], 1'b1);
    apb(1'b0, `IOAC_EVENT_OFS, 32'h0);
    check(rd[4], 1'b1);
    wait_cyc(3);
    check(irq, 1'b0);
    apb(1'b1, `IOAC_ACK_OFS, 32'h1);
    wait_cyc(3);
    check(dout, 1'b1);
    host <= 1'b0;
  endtask
  task automatic t_sensor_overload();
    apb(1'b1, `IOAC_MASK_OFS, 32'h0);
    sensor_short <= 1'b1;
    switch_on <= 4'h1;
    motor_off <= 1'b1;
    wait_cyc(30);
    check(action_cmd, '0);
    sensor_short <= 1'b0;
    switch_on <= 4'h0;
    motor_off <= 1'b0;
    wait_cyc(30);
    check(irq, 1'b0);
    apb(1'b0, `IOAC_STATUS_OFS, 32'h0);
    check(rd[4], 1'b1);
    apb(1'b0, `IOAC_EVENT_OFS, 32'h0);
    check(rd[3], 1'b1);
    apb(1'b1, `IOAC_ACK_OFS, 32'h1);
    apb(1'b0, `IOAC_STATUS_OFS, 32'h0);
    check(rd[4], 1'b0);
  endtask
  task automatic t_unmapped();
    apb(1'b1, 12'h040, 32'hffff_ffff);
    check(err, 1'b1);
    apb(1'b0, 12'h040, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_host_and_invert();
    t_flash();
    t_starter_sources();
    t_input_filter();
    t_input_actions();
    t_output_overload();
    t_sensor_overload();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire
